// *** hw/irq_prio_top.sv ***
// request latching, priority encoding and axi4-lite register file
// How it works
// - a port c pin request sets its pending bit in group-two request register
// - with global enable set, a pending enabled request goes to the core
// - with global enable clear, requests stay pending and are not forwarded; they are polled or flagged on the masked summary irq
// - group-two bits 3..0 are port c pins, bits 7..4 reserved zero
// - enable pair 00 off, 01 low, 10 medium, 11 high priority
// - group-zero bits 0..7 each have their own enable pair
// - each port c request 3..0 has its own enable-low bit
// - edge select 0 makes port a pin request on falling edge
// - edge select 1 makes port a pin request on rising edge
// - edge select register holds one bit per port a pin
// - shared source select picks port a pin or alternate source
// - switching shared source can itself make an edge and request
`timescale 1ns/1ps
module irq_prio_top import irq_prio_pkg::*; (
   input  wire logic              core_clk,       // 125 MHz system clock
   input  wire logic              rst,            // sync reset, high
   input  wire logic [7:0]        porta_pin_input, // port a pins
   input  wire logic [7:0]        alt_source,     // alternate shared sources
   input  wire logic [3:0]        portc_pin,      // port c pin levels
   input  wire logic              irq_ack,        // core accepted forwarded request
   output logic                   core_irq,       // vectored request to core
   output logic [3:0]             core_vector,    // winning source, 0..7 zero, 8..11 two
   output logic [1:0]             core_level,     // winning level
   output logic                   irq,            // summary interrupt
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,   // write address
   input  wire logic              s_axi_awvalid,  // write address valid
   output logic                   s_axi_awready,  // write address ready
   input  wire logic [31:0]       s_axi_wdata,    // write data
   input  wire logic [3:0]        s_axi_wstrb,    // byte strobes
   input  wire logic              s_axi_wvalid,   // write data valid
   output logic                   s_axi_wready,   // write data ready
   output logic [1:0]             s_axi_bresp,    // write response
   output logic                   s_axi_bvalid,   // write response valid
   input  wire logic              s_axi_bready,   // write response ready
   input  wire logic [ADDR_W-1:0] s_axi_araddr,   // read address
   input  wire logic              s_axi_arvalid,  // read address valid
   output logic                   s_axi_arready,  // read address ready
   output logic [31:0]            s_axi_rdata,    // read data
   output logic [1:0]             s_axi_rresp,    // read response
   output logic                   s_axi_rvalid,   // read data valid
   input  wire logic              s_axi_rready    // read data ready
);
   // registers
   logic [7:0] request_group_two;
   logic [7:0] request_group_zero;
   logic [7:0] group_zero_enable_high;
   logic [7:0] group_zero_enable_low;
   logic [7:0] two_enable_high;
   logic [7:0] two_enable_low;   // holds portc3..0_enable_low
   logic [7:0] edge_select_register;
   logic [7:0] shared_source_select;
   logic [7:0] ctrl;
   logic [7:0] status;
   logic [7:0] mask;

   // write channel capture
   logic              aw_held;
   logic              w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0]       w_data;
   logic [3:0]        w_strb;

   // request sources
   logic [7:0] shared_porta_interrupt;
   logic [7:0] zero_edge;
   logic [3:0] portc_edge;
   logic [7:0] shared_level;
   pick_s      pick;

   // pins from outside: two stages before the source mux reads them
   // costs two cycles of request latency; no raw pin level ever meets logic
   logic [7:0] porta_sync_a;
   logic [7:0] porta_sync_b;
   logic [7:0] alt_sync_a;
   logic [7:0] alt_sync_b;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         porta_sync_a <= RST_BYTE;
         porta_sync_b <= RST_BYTE;
         alt_sync_a   <= RST_BYTE;
         alt_sync_b   <= RST_BYTE;
      end else begin
         porta_sync_a <= porta_pin_input;
         porta_sync_b <= porta_sync_a;
         alt_sync_a   <= alt_source;
         alt_sync_b   <= alt_sync_a;
      end
   end

   // shared request: port a pin or alternate source, then edge-sensed
   assign shared_level = (shared_source_select & alt_sync_b)
                       | (~shared_source_select & porta_sync_b);

   // a source switch is just another edge to the detector
   edge_sense #(.W(8)) u_zero_edge (
      .core_clk   (core_clk),
      .rst        (rst),
      .pin_async  (shared_level),
      .rise_sel   (edge_select_register),
      .edge_pulse (zero_edge)
   );
   assign shared_porta_interrupt = zero_edge;

   // port c requests on rising edge
   edge_sense #(.W(4)) u_portc_edge (
      .core_clk   (core_clk),
      .rst        (rst),
      .pin_async  (portc_pin),
      .rise_sel   (4'hF),
      .edge_pulse (portc_edge)
   );

   // twelve sources, each with its own enable pair
   prio_pick #(.N(12)) u_pick (
      .pend  ({request_group_two[3:0], request_group_zero}),
      .en_hi ({two_enable_high[3:0], group_zero_enable_high}),
      .en_lo ({two_enable_low[3:0], group_zero_enable_low}),
      .pick  (pick)
   );

   // bus decode
   wire        wr_fire  = aw_held && w_held && !s_axi_bvalid;
   wire [11:0] wr_idx   = addr_index(aw_addr);
   wire        wr_lane  = w_strb[0];
   wire [7:0]  wr_byte  = w_data[7:0];
   wire        wr_req2  = wr_fire && wr_lane && wr_idx == IDX_REQ_TWO;
   wire        wr_req0  = wr_fire && wr_lane && wr_idx == IDX_REQ_ZERO;
   wire        wr_stat  = wr_fire && wr_lane && wr_idx == IDX_STATUS;
   wire        wr_hit   = wr_idx == IDX_REQ_TWO  || wr_idx == IDX_EDGE_SEL
                       || wr_idx == IDX_REQ_ZERO || wr_idx == IDX_ZERO_ENH
                       || wr_idx == IDX_ZERO_ENL || wr_idx == IDX_TWO_ENH
                       || wr_idx == IDX_TWO_ENL  || wr_idx == IDX_SHARED
                       || wr_idx == IDX_CTRL     || wr_idx == IDX_STATUS
                       || wr_idx == IDX_MASK;
   wire [11:0] rd_idx   = addr_index(s_axi_araddr);
   wire        rd_fire  = s_axi_arvalid && s_axi_arready;
   wire        global_en = ctrl[CTRL_GLOBAL_EN];

   // write one clears a pending bit; software writes of zero leave it
   wire [7:0] clr_two  = wr_req2 ? wr_byte : 8'h00;
   wire [7:0] clr_zero = wr_req0 ? wr_byte : 8'h00;

   // next pending: new edge wins over a same-cycle clear
   wire [7:0] next_request_group_two =
      ((request_group_two & ~clr_two) | {4'h0, portc_edge}) & REQ_TWO_MASK;
   wire [7:0] next_request_group_zero =
      (request_group_zero & ~clr_zero) | shared_porta_interrupt;

   // status events
   wire [EV_W-1:0] events = {core_irq && irq_ack, |shared_porta_interrupt, |portc_edge};
   wire [7:0] next_status =
      (status & ~(wr_stat ? wr_byte : 8'h00)) | {{(8-EV_W){1'b0}}, events};

   // read mux
   logic [7:0] rd_byte;
   logic       rd_hit;
   always_comb begin
      rd_hit  = 1'b1;
      case (rd_idx)
         IDX_REQ_TWO:  rd_byte = request_group_two;  // polling path
         IDX_EDGE_SEL: rd_byte = edge_select_register;
         IDX_REQ_ZERO: rd_byte = request_group_zero;
         IDX_ZERO_ENH: rd_byte = group_zero_enable_high;
         IDX_ZERO_ENL: rd_byte = group_zero_enable_low;
         IDX_TWO_ENH:  rd_byte = two_enable_high;
         IDX_TWO_ENL:  rd_byte = two_enable_low;
         IDX_SHARED:   rd_byte = shared_source_select;
         IDX_CTRL:     rd_byte = ctrl;
         IDX_STATUS:   rd_byte = status;
         IDX_MASK:     rd_byte = mask;
         default: begin
            rd_byte = 8'h00;
            rd_hit  = 1'b0;
         end
      endcase
   end

   // axi write address and data capture, either order
   always_ff @(posedge core_clk) begin
      if (rst) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= '0;
         w_data  <= '0;
         w_strb  <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
      end else begin
         // readies are flops: low from take until the response is accepted
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // axi read: one cycle to answer
   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
         s_axi_arready <= 1'b1;
      end else if (rd_fire) begin
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= {24'h0, rd_byte};
         s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         s_axi_arready <= 1'b0;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // configuration registers, byte lane 0 only
   always_ff @(posedge core_clk) begin
      if (rst) begin
         edge_select_register   <= RST_BYTE;
         group_zero_enable_high <= RST_BYTE;
         group_zero_enable_low  <= RST_BYTE;
         two_enable_high        <= RST_BYTE;
         two_enable_low         <= RST_BYTE;
         shared_source_select   <= RST_BYTE;
         ctrl                   <= RST_BYTE;
         mask                   <= RST_BYTE;
      end else if (wr_fire && wr_lane) begin
         case (wr_idx)
            IDX_EDGE_SEL: edge_select_register   <= wr_byte;
            IDX_ZERO_ENH: group_zero_enable_high <= wr_byte;
            IDX_ZERO_ENL: group_zero_enable_low  <= wr_byte;
            IDX_TWO_ENH:  two_enable_high        <= wr_byte & REQ_TWO_MASK;
            IDX_TWO_ENL:  two_enable_low         <= wr_byte & REQ_TWO_MASK;
            // software must disable the request first; no interlock here
            IDX_SHARED:   shared_source_select   <= wr_byte;
            IDX_CTRL:     ctrl                   <= wr_byte;
            IDX_MASK:     mask                   <= wr_byte;
            default:      ctrl                   <= ctrl;
         endcase
      end
   end

   // pending, status and forwarding to the core
   always_ff @(posedge core_clk) begin
      if (rst) begin
         request_group_two  <= RST_BYTE;
         request_group_zero <= RST_BYTE;
         status             <= RST_BYTE;
         core_irq           <= 1'b0;
         core_vector        <= 4'h0;
         core_level         <= 2'h0;
         irq                <= 1'b0;
      end else begin
         request_group_two  <= next_request_group_two;
         request_group_zero <= next_request_group_zero;
         status             <= next_status;
         irq                <= |(next_status & mask);
         // disabled globally: nothing forwarded, bits stay for polling
         core_irq    <= global_en && pick.valid;
         core_vector <= pick.source;
         core_level  <= pick.level;
      end
   end

   // assertions
   req_two_set_a: assert property (@(posedge core_clk) disable iff (rst)
      portc_edge[0] |=> request_group_two[0])
      else $error("port c edge did not set pending");
   req_two_rsv_a: assert property (@(posedge core_clk) disable iff (rst)
      request_group_two[7:4] == 4'h0)
      else $error("reserved pending bits set");
   fwd_on_a: assert property (@(posedge core_clk) disable iff (rst)
      (global_en && pick.valid) |=> core_irq)
      else $error("enabled request not forwarded");
   hold_off_a: assert property (@(posedge core_clk) disable iff (rst)
      !global_en |=> !core_irq)
      else $error("request forwarded while disabled");
   prio_off_a: assert property (@(posedge core_clk) disable iff (rst)
      (pick.valid |-> pick.level != LVL_OFF))
      else $error("disabled pair won");
   sticky_two_a: assert property (@(posedge core_clk) disable iff (rst)
      (request_group_two[2] && !wr_req2) |=> request_group_two[2])
      else $error("pending bit lost without a clear");
   sticky_zero_a: assert property (@(posedge core_clk) disable iff (rst)
      (request_group_zero[5] && !wr_req0) |=> request_group_zero[5])
      else $error("group zero pending lost");
   zero_set_a: assert property (@(posedge core_clk) disable iff (rst)
      zero_edge[3] |=> request_group_zero[3])
      else $error("edge did not set group zero");
   irq_out_a: assert property (@(posedge core_clk) disable iff (rst)
      irq == |(status & $past(mask)))
      else $error("summary interrupt mismatch");

endmodule // irq_prio_top

// *** hw/irq_prio_pkg.sv ***
// shared constants and types for the request and priority block
package irq_prio_pkg;

   // register word indices (printed offsets are all multiples of four: index * 4)
   localparam logic [11:0] IDX_REQ_TWO   = 12'hFC6;
   localparam logic [11:0] IDX_EDGE_SEL  = 12'hFCD;
   localparam logic [11:0] IDX_REQ_ZERO  = 12'hFC0;
   localparam logic [11:0] IDX_ZERO_ENH  = 12'hFC1;
   localparam logic [11:0] IDX_ZERO_ENL  = 12'hFC2;
   localparam logic [11:0] IDX_TWO_ENH   = 12'hFC7;
   localparam logic [11:0] IDX_TWO_ENL   = 12'hFC8;
   localparam logic [11:0] IDX_SHARED    = 12'hFCE;
   localparam logic [11:0] IDX_CTRL      = 12'hFCF;
   localparam logic [11:0] IDX_STATUS    = 12'hFD0;
   localparam logic [11:0] IDX_MASK      = 12'hFD1;

   localparam int ADDR_W = 14;

   // reset values
   localparam logic [7:0] RST_BYTE   = 8'h00;
   // valid bits of the group-two request register
   localparam logic [7:0] REQ_TWO_MASK = 8'h0F;

   // status event bits
   localparam int EV_REQ_TWO   = 0;
   localparam int EV_REQ_ZERO  = 1;
   localparam int EV_FORWARD   = 2;
   localparam int EV_W         = 3;

   // control register field
   localparam int CTRL_GLOBAL_EN = 0;

   // axi response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // priority levels
   typedef enum logic [1:0] {
      LVL_OFF  = 2'h0,
      LVL_LOW  = 2'h1,
      LVL_MED  = 2'h2,
      LVL_HIGH = 2'h3
   } level_e;

   // result of priority selection
   typedef struct packed {
      logic       valid;
      logic [3:0] source;
      level_e     level;
   } pick_s;

   // combine enable pair into level
   function automatic level_e pair_level(input logic hi, input logic lo);
      return level_e'({hi, lo});
   endfunction

   function automatic logic [11:0] addr_index(input logic [ADDR_W-1:0] a);
      return a[ADDR_W-1:2];
   endfunction

endpackage

// *** hw/edge_sense.sv ***
// per-pin synchroniser and edge detector with selectable polarity
`timescale 1ns/1ps
module edge_sense import irq_prio_pkg::*; #(
   parameter int W = 8
) (
   input  wire logic         core_clk,    // system clock
   input  wire logic         rst,         // sync reset
   input  wire logic [W-1:0] pin_async,   // raw pin level
   input  wire logic [W-1:0] rise_sel,    // 1 rising, 0 falling
   output logic      [W-1:0] edge_pulse   // one cycle per edge
);
   logic [W-1:0] sync_a;
   logic [W-1:0] sync_b;
   logic [W-1:0] last;

   // two stages before use; only sync_b and last are looked at
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sync_a <= '0;
         sync_b <= '0;
         last   <= '0;
      end else begin
         sync_a <= pin_async;
         sync_b <= sync_a;
         last   <= sync_b;
      end
   end

   // polarity chosen per pin
   assign edge_pulse = (rise_sel & sync_b & ~last)
                     | (~rise_sel & ~sync_b & last);
endmodule // edge_sense

// *** hw/prio_pick.sv ***
// picks the highest-level pending request, lowest index wins a tie
`timescale 1ns/1ps
module prio_pick import irq_prio_pkg::*; #(
   parameter int N = 12
) (
   input  wire logic [N-1:0] pend,   // pending requests
   input  wire logic [N-1:0] en_hi,  // enable high bits
   input  wire logic [N-1:0] en_lo,  // enable low bits
   output pick_s             pick    // winner
);
   always_comb begin
      pick = '0;
      for (int i = N - 1; i >= 0; i--) begin
         // 00 never wins: that pair disables the request
         if (pend[i] && pair_level(en_hi[i], en_lo[i]) != LVL_OFF &&
             pair_level(en_hi[i], en_lo[i]) >= pick.level) begin
            pick.valid  = 1'b1;
            pick.source = 4'(i);
            pick.level  = pair_level(en_hi[i], en_lo[i]);
         end
      end
   end
endmodule // prio_pick

// *** tb/core_model.sv ***
// processor core stand-in that takes forwarded requests and accepts them
`timescale 1ns/1ps
module core_model (
   input  wire logic       core_clk,    // system clock
   input  wire logic       rst,         // sync reset, high
   input  wire logic       core_irq,    // forwarded request
   input  wire logic [3:0] core_vector, // winning source
   input  wire logic [1:0] core_level,  // winning level
   input  wire logic       slow,        // stretch the service delay
   output logic            irq_ack,     // one-cycle accept
   output logic [3:0]      seen_vector, // vector held at accept
   output logic [1:0]      seen_level   // level held at accept
);
   logic [3:0] wait_cnt;

   // one accept per raised request, after a short or a long delay
   always_ff @(posedge core_clk) begin
      if (rst) begin
         irq_ack     <= 1'b0;
         wait_cnt    <= 4'h1;
         seen_vector <= 4'h0;
         seen_level  <= 2'h0;
      end else begin
         irq_ack <= 1'b0;
         if (!core_irq) begin
            wait_cnt <= slow ? 4'hC : 4'h1;
         end else if (wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
            if (wait_cnt == 4'h1) begin
               irq_ack     <= 1'b1;
               seen_vector <= core_vector;
               seen_level  <= core_level;
            end
         end
      end
   end
endmodule // core_model

// *** tb/gpio_interrupt_request_priority_bench.sv ***
// self-checking bench for the request and priority block
`timescale 1ns/1ps
module gpio_interrupt_request_priority_bench import irq_prio_pkg::*;;
   logic              core_clk, rst, irq_ack, core_irq, irq, slow;
   logic [7:0]        porta_pin_input, alt_source, es;
   logic [3:0]        portc_pin, core_vector, seen_vector, wstrb;
   logic [1:0]        core_level, seen_level, bresp, rresp;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0]       wdata, rdata;
   logic              awvalid, awready, wvalid, wready, bvalid, bready;
   logic              arvalid, arready, rvalid, rready;
   logic [33:0]       rq[$];
   logic [33:0]       bq[$];
   logic [6:0]        exp_pick[1:3];
   int                fails, checked;

   irq_prio_top dut (
      .core_clk(core_clk), .rst(rst), .porta_pin_input(porta_pin_input),
      .alt_source(alt_source), .portc_pin(portc_pin), .irq_ack(irq_ack),
      .core_irq(core_irq), .core_vector(core_vector), .core_level(core_level), .irq(irq),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready)
   );

   core_model core (
      .core_clk(core_clk), .rst(rst), .core_irq(core_irq), .core_vector(core_vector),
      .core_level(core_level), .slow(slow), .irq_ack(irq_ack),
      .seen_vector(seen_vector), .seen_level(seen_level)
   );

   task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // write: both items offered together, each dropped once taken
   task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] resp);
      logic a, w;
      bq.push_back({32'h00000000, resp});
      @(posedge core_clk);
      awaddr  <= {idx, 2'h0};
      wdata   <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      a = 1'b0;
      w = 1'b0;
      // valid is held, so ready seen mid-cycle means taken at the next edge
      while (!(a && w)) begin
         @(negedge core_clk);
         a = a || awready;
         w = w || wready;
         @(posedge core_clk);
         if (a) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end
      do begin
         @(negedge core_clk);
         a = bvalid;
         @(posedge core_clk);
      end while (!a);
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] resp);
      logic r;
      rq.push_back({resp, 24'h000000, d});
      @(posedge core_clk);
      araddr  <= {idx, 2'h0};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(negedge core_clk);
         r = arready;
         @(posedge core_clk);
      end while (!r);
      arvalid <= 1'b0;
      do begin
         @(negedge core_clk);
         r = rvalid;
         @(posedge core_clk);
      end while (!r);
      rready <= 1'b0;
   endtask

   // clear group-zero pending, move the pins, then poll what was latched
   task automatic pa_step(input logic [7:0] pa, input logic [7:0] alt, input logic [7:0] exp);
      wr(IDX_REQ_ZERO, 8'hFF, RESP_OKAY);
      @(posedge core_clk);
      porta_pin_input <= pa;
      alt_source      <= alt;
      repeat (8) @(posedge core_clk);
      rd(IDX_REQ_ZERO, exp, RESP_OKAY);
   endtask

   // responses are compared mid-cycle, where they are settled
   always @(negedge core_clk) begin
      if (bvalid && bready) check("bresp", {32'h00000000, bresp}, bq.pop_front());
      if (rvalid && rready) check("read", {rresp, rdata}, rq.pop_front());
   end

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // hang guard, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge core_clk);
      fails++;
      complete_run();
   end

   initial begin
      fails = 0;
      checked = 0;
      rst = 1'b1;
      {porta_pin_input, alt_source, portc_pin} = 20'h00000;
      {awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      wstrb = 4'hF;
      slow = 1'b1;
      exp_pick[1] = {1'b1, 4'hA, 2'h2};
      exp_pick[2] = {1'b1, 4'hB, 2'h1};
      exp_pick[3] = 7'h00;
      void'($urandom(32'h774D));
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      rd(IDX_REQ_TWO, RST_BYTE, RESP_OKAY);
      rd(IDX_EDGE_SEL, RST_BYTE, RESP_OKAY);
      es = 8'($urandom());
      wr(IDX_EDGE_SEL, es, RESP_OKAY);
      rd(IDX_EDGE_SEL, es, RESP_OKAY);
      pa_step(8'hFF, 8'h00, es);
      pa_step(8'h00, 8'h00, ~es);
      wr(IDX_EDGE_SEL, 8'hFF, RESP_OKAY);
      pa_step(8'h00, 8'hFF, 8'h00);
      // group-zero enables are still off while the source is switched
      wr(IDX_REQ_ZERO, 8'hFF, RESP_OKAY);
      wr(IDX_SHARED, 8'hFF, RESP_OKAY);
      repeat (8) @(posedge core_clk);
      rd(IDX_REQ_ZERO, 8'hFF, RESP_OKAY);
      pa_step(8'hFF, 8'h00, 8'h00);
      pa_step(8'h00, 8'hFF, 8'hFF);
      // port c: pin0 off, pin1 high, pin2 medium, pin3 low
      wr(IDX_TWO_ENH, 8'h06, RESP_OKAY);
      wr(IDX_TWO_ENL, 8'h0A, RESP_OKAY);
      @(posedge core_clk);
      portc_pin <= 4'hF;
      repeat (8) @(posedge core_clk);
      portc_pin <= 4'h0;
      repeat (8) @(posedge core_clk);
      rd(IDX_REQ_TWO, 8'h0F, RESP_OKAY);
      @(negedge core_clk);
      check("core_irq", 34'(core_irq), 34'h0);
      wr(IDX_MASK, 8'h01, RESP_OKAY);
      repeat (3) @(negedge core_clk);
      check("irq", 34'(irq), 34'h1);
      wr(IDX_STATUS, 8'h01, RESP_OKAY);
      repeat (3) @(negedge core_clk);
      check("irq", 34'(irq), 34'h0);
      wr(IDX_CTRL, 8'h01, RESP_OKAY);
      repeat (4) @(negedge core_clk);
      check("pick", 34'({core_irq, core_vector, core_level}), 34'h67);
      repeat (16) @(negedge core_clk);
      check("accepted", 34'({seen_vector, seen_level}), 34'h27);
      // port c event cleared; shared event and accepted forward still flagged
      rd(IDX_STATUS, 8'h06, RESP_OKAY);
      for (int i = 1; i < 4; i++) begin
         wr(IDX_REQ_TWO, 8'(1 << i), RESP_OKAY);
         repeat (4) @(negedge core_clk);
         check("pick", 34'({core_irq, core_irq ? {core_vector, core_level} : 6'h00}),
               34'(exp_pick[i]));
      end
      rd(IDX_REQ_TWO, 8'h01, RESP_OKAY);
      wr(12'hFFF, 8'h5A, RESP_SLVERR);
      rd(12'hFFF, 8'h00, RESP_SLVERR);
      complete_run();
   end
endmodule // gpio_interrupt_request_priority_bench
